// ==== dadc_pkg.sv ====
/*
 Shared constants and types of the dual-channel result processing block.
 Assumes a 125 MHz pclk and an APB master with 32-bit data.
*/
package dadc_pkg;
	localparam int CLK_MHZ = 125;
	localparam int SAMP_US_20 = 20;
	localparam int SAMP_US_40 = 40;
	localparam int SAMP_US_80 = 80;
	localparam int CYC_20 = SAMP_US_20 * CLK_MHZ;
	localparam int CYC_40 = SAMP_US_40 * CLK_MHZ;
	localparam int CYC_80 = SAMP_US_80 * CLK_MHZ;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
	localparam int LIM_HI = 32384;
	localparam int LIM_BI_LO = -32384;
	localparam int LIM_UNI_LO = -384;
	localparam int LZ_ZERO = 6400;
	localparam int LOG_DEPTH = 2000;
	localparam int AVG_MAX = 1000;
	localparam int MA_DEPTH = 1024;
	localparam int GAIN_FRAC = 12;
	localparam int LP_FRAC = 8;
	localparam logic [15:0] GAIN_RST = 16'h1000;
	localparam logic [15:0] CLIP_MAX_RST = 16'h7E80;
	localparam logic [15:0] CLIP_MIN_RST = 16'h8180;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG0 = 8'h04;
	localparam logic [7:0] OFS_CFG1 = 8'h08;
	localparam logic [7:0] OFS_CAL0 = 8'h0C;
	localparam logic [7:0] OFS_CAL1 = 8'h10;
	localparam logic [7:0] OFS_CLIP0 = 8'h14;
	localparam logic [7:0] OFS_CLIP1 = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1C;
	localparam logic [7:0] OFS_RES0 = 8'h20;
	localparam logic [7:0] OFS_RES1 = 8'h24;
	localparam logic [7:0] OFS_PEAK0 = 8'h28;
	localparam logic [7:0] OFS_PEAK1 = 8'h2C;
	localparam logic [7:0] OFS_LIDX = 8'h30;
	localparam logic [7:0] OFS_LOG0 = 8'h34;
	localparam logic [7:0] OFS_LOG1 = 8'h38;
	localparam int CTL_RUN = 0;
	localparam int CTL_CYC = 1;
	localparam int CTL_TEN = 3;
	localparam int CTL_FALL = 5;
	localparam int CTL_LOG = 7;
	localparam int CTL_CLR = 8;
	localparam int CFG_RNG = 0;
	localparam int CFG_AVG = 3;
	localparam int CFG_CNT = 5;
	localparam int CFG_FLT = 15;
	localparam int CFG_SH = 17;
	localparam logic [20:0] CFG_RST = 21'h000020;
	typedef enum logic [2:0] {RNG_BI10, RNG_UNI10, RNG_BI5, RNG_UNI5, RNG_LZ5, RNG_BI20MA, RNG_UNI20MA,
		RNG_LZ20MA} dadc_range_t;
	typedef enum logic [1:0] {AVG_OFF, AVG_TIME, AVG_MOVE, AVG_RSV} dadc_avg_t;
	typedef enum logic [1:0] {FLT_OFF, FLT_LP, FLT_BP, FLT_RSV} dadc_flt_t;
	typedef struct packed {
		logic signed [15:0] code;
		logic hi;
		logic lo;
	} dadc_sample_t;
	typedef struct packed {
		dadc_flt_t flt;
		logic [3:0] sh;
		dadc_avg_t avg;
		logic [9:0] cnt;
	} dadc_proc_t;
	typedef struct packed {
		logic signed [15:0] max;
		logic signed [15:0] min;
		logic signed [15:0] offs;
		logic [15:0] gain;
		dadc_range_t rng;
	} dadc_cal_t;

	function automatic logic dadc_bipolar(input dadc_range_t r);
		return r == RNG_BI10 || r == RNG_BI5 || r == RNG_BI20MA;
	endfunction : dadc_bipolar

	function automatic logic dadc_livezero(input dadc_range_t r);
		return r == RNG_LZ5 || r == RNG_LZ20MA;
	endfunction : dadc_livezero
endpackage : dadc_pkg

// ==== dadc_chan.sv ====
/*
 Per-channel scaling, limit check and calibration, two register stages.
 Assumes raw codes where rated full scale of the selected range is 32000.
*/
`timescale 1ns/1ps
module dadc_chan
	import dadc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	input wire dadc_sample_t smp,
	input wire dadc_cal_t cal,
	output logic out_valid,
	output logic signed [15:0] res,
	output logic lim_err,
	output logic open_wire
);
	logic signed [17:0] d;
	logic signed [17:0] lo_b;
	logic signed [16:0] lim_next;
	logic signed [16:0] lim_reg;
	logic v1_reg;
	logic err_next;
	logic signed [34:0] prod;
	logic signed [21:0] y;

	always_comb
	begin
		d = 18'(smp.code);
		if (dadc_livezero(cal.rng))
		begin
			d = d - 18'(LZ_ZERO);
			d = d + (d >>> 2);
		end
		lo_b = dadc_bipolar(cal.rng) ? 18'(LIM_BI_LO) : 18'(LIM_UNI_LO);
		err_next = smp.hi | smp.lo | (d > 18'(LIM_HI)) | (d < lo_b);
		if (smp.hi || d > 18'(LIM_HI))
			lim_next = 17'(LIM_HI);
		else if (smp.lo || d < lo_b)
			lim_next = 17'(lo_b);
		else
			lim_next = 17'(d);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			v1_reg <= 1'b0;
			lim_reg <= '0;
			lim_err <= 1'b0;
			open_wire <= 1'b0;
		end
		else
		begin
			v1_reg <= in_valid;
			if (in_valid)
			begin
				lim_reg <= lim_next;
				lim_err <= err_next;
				open_wire <= dadc_livezero(cal.rng) & smp.lo;
			end
		end
	end

	always_comb
	begin
		prod = 35'(lim_reg) * 35'($signed({1'b0, cal.gain}));
		// Wide enough for full gain on a limit value, so clipping never sees a wrapped sum.
		y = 22'(prod >>> GAIN_FRAC) + 22'(cal.offs);
		if (y > 22'(cal.max))
			y = 22'(cal.max);
		else if (y < 22'(cal.min))
			y = 22'(cal.min);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_valid <= 1'b0;
			res <= '0;
		end
		else
		begin
			out_valid <= v1_reg;
			if (v1_reg)
				res <= y[15:0];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	hw_high_a: assert property (in_valid && smp.hi |=> lim_err && lim_reg == 17'(LIM_HI))
		else $error("High hardware limit not forced to upper conversion limit");
	sat_low_a: assert property (in_valid && smp.lo && !smp.hi |=> lim_err && 18'(lim_reg) == $past(lo_b))
		else $error("Low hardware limit not forced to lower conversion limit");
	conv_bound_a: assert property (v1_reg |-> lim_reg <= 17'(LIM_HI) && lim_reg >= 17'(LIM_BI_LO))
		else $error("Limited value outside conversion limit");
	clip_out_a: assert property (v1_reg && cal.min <= cal.max |=> res <= $past(cal.max) && res >= $past(cal.min))
		else $error("Calibrated result not clipped");
	open_range_a: assert property (in_valid && !dadc_livezero(cal.rng) |=> !open_wire)
		else $error("Disconnection flagged outside live-zero range");
endmodule : dadc_chan

// ==== dadc_filt.sv ====
/*
 Per-channel low-pass or band-pass filter followed by time or moving averaging.
 Assumes samples arrive far apart compared with one pclk.
*/
`timescale 1ns/1ps
module dadc_filt
	import dadc_pkg::*;
#(
	parameter int DEPTH = MA_DEPTH
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic in_valid,
	input wire logic signed [15:0] x,
	input wire dadc_proc_t cfg,
	output logic out_valid,
	output logic signed [15:0] y
);
	logic signed [15:0] win [DEPTH];
	logic signed [23:0] lp1_reg;
	logic signed [23:0] lp2_reg;
	logic signed [23:0] xs;
	logic signed [23:0] lp1_next;
	logic signed [23:0] lp2_next;
	logic signed [15:0] f;
	logic signed [26:0] sum_reg;
	logic signed [26:0] sum_next;
	logic [9:0] wr_reg;
	logic [9:0] fill_reg;
	logic [9:0] k_reg;
	logic [9:0] n;

	function automatic logic signed [15:0] avg_div(input logic signed [26:0] s, input logic [9:0] c);
		return 16'(s / $signed({17'h00000, c}));
	endfunction : avg_div

	always_comb
	begin
		n = (cfg.cnt == 10'h000) ? 10'h001 : (cfg.cnt > 10'(AVG_MAX)) ? 10'(AVG_MAX) : cfg.cnt;
		xs = 24'(x) <<< LP_FRAC;
		lp1_next = lp1_reg + ((xs - lp1_reg) >>> cfg.sh);
		lp2_next = lp2_reg + ((xs - lp2_reg) >>> (5'(cfg.sh) + 5'h02));
		if (cfg.flt == FLT_LP)
			f = 16'(lp1_next >>> LP_FRAC);
		else if (cfg.flt == FLT_BP)
			f = 16'((lp1_next - lp2_next) >>> LP_FRAC);
		else
			f = x;
		sum_next = sum_reg + 27'(f);
		if (cfg.avg == AVG_MOVE && fill_reg >= n)
			sum_next = sum_next - 27'(win[10'(wr_reg - n)]);
	end

	always_ff @(posedge pclk)
	begin
		if (in_valid)
			win[wr_reg] <= f;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lp1_reg <= '0;
			lp2_reg <= '0;
			sum_reg <= '0;
			wr_reg <= '0;
			fill_reg <= '0;
			k_reg <= '0;
			out_valid <= 1'b0;
			y <= '0;
		end
		else if (clr)
		begin
			sum_reg <= '0;
			fill_reg <= '0;
			k_reg <= '0;
			out_valid <= 1'b0;
		end
		else
		begin
			out_valid <= 1'b0;
			if (in_valid)
			begin
				lp1_reg <= lp1_next;
				lp2_reg <= lp2_next;
				wr_reg <= wr_reg + 10'h001;
				if (cfg.avg == AVG_MOVE)
				begin
					sum_reg <= sum_next;
					fill_reg <= (fill_reg >= n) ? n : fill_reg + 10'h001;
					y <= avg_div(sum_next, (fill_reg >= n) ? n : fill_reg + 10'h001);
					out_valid <= 1'b1;
				end
				else if (cfg.avg == AVG_TIME)
				begin
					if (k_reg + 10'h001 >= n)
					begin
						y <= avg_div(sum_next, n);
						out_valid <= 1'b1;
						sum_reg <= '0;
						k_reg <= '0;
					end
					else
					begin
						sum_reg <= sum_next;
						k_reg <= k_reg + 10'h001;
					end
				end
				else
				begin
					y <= f;
					out_valid <= 1'b1;
				end
			end
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	time_avg_a: assert property (in_valid && !clr && cfg.avg == AVG_TIME && k_reg + 10'h001 < n |=> !out_valid)
		else $error("Time average emitted before its count");
endmodule : dadc_filt

// ==== dadc_top.sv ====
/*
 Dual-channel result processing: APB registers, sample timing, triggers,
 per-channel processing, peak and logging, indicator drive.
 Assumes a front end that converts both channels on adc_start and answers
 with one adc_valid pulse, on pclk.
*/
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module dadc_top
	import dadc_pkg::*;
#(
	parameter int P_CYC_20 = CYC_20,
	parameter int P_CYC_40 = CYC_40,
	parameter int P_CYC_80 = CYC_80,
	parameter int P_BLINK = BLINK_CYC,
	parameter int ADDR_W = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dadc_sample_t [1:0] adc_smp,
	input wire logic adc_valid,
	output logic adc_start,
	input wire logic [1:0] trig_pin,
	output logic led_err,
	output logic led_conv,
	output logic [1:0] led_in
);
	logic [8:0] ctrl_reg;
	logic [20:0] cfg_reg [2];
	logic [31:0] cal_reg [2];
	logic [31:0] clip_reg [2];
	logic [1:0] lim_st_reg;
	logic [1:0] ow_st_reg;
	logic [1:0] new_st_reg;
	logic signed [15:0] res_reg [2];
	logic signed [15:0] peak_reg [2];
	logic [10:0] log_cnt_reg [2];
	logic [10:0] lidx_reg;
	logic signed [15:0] log_mem [2][LOG_DEPTH];
	logic [1:0] trig_s1_reg;
	logic [1:0] trig_s2_reg;
	logic [1:0] trig_s3_reg;
	logic [1:0] edge_hit;
	logic [15:0] tmr_reg;
	logic [15:0] period;
	logic tick;
	logic start_next;
	logic busy_reg;
	logic [1:0] acc_reg;
	logic [1:0] acc_next;
	logic [31:0] blink_cnt_reg;
	logic blink_reg;
	logic wr_en;
	logic clr_pulse;
	logic [7:0] addr;
	logic [31:0] rdata_next;
	logic rerr_next;
	logic [1:0] ch_in;
	logic [1:0] ch_ov;
	logic [1:0] ch_lim;
	logic [1:0] ch_ow;
	logic signed [15:0] ch_res [2];
	logic [1:0] fl_ov;
	logic signed [15:0] fl_y [2];
	dadc_cal_t cal [2];
	dadc_proc_t proc [2];

	assign addr = 8'(paddr);
	assign wr_en = psel & penable & pready & pwrite;
	assign clr_pulse = wr_en && addr == OFS_CTRL && pwdata[CTL_CLR];

	// Registered answer: no wait state, so every access ends on its first access edge.
	always_comb
	begin
		rdata_next = 32'h00000000;
		rerr_next = 1'b0;
		if (addr == OFS_CTRL)
			rdata_next = 32'(ctrl_reg[7:0]);
		else if (addr == OFS_CFG0)
			rdata_next = 32'(cfg_reg[0]);
		else if (addr == OFS_CFG1)
			rdata_next = 32'(cfg_reg[1]);
		else if (addr == OFS_CAL0)
			rdata_next = cal_reg[0];
		else if (addr == OFS_CAL1)
			rdata_next = cal_reg[1];
		else if (addr == OFS_CLIP0)
			rdata_next = clip_reg[0];
		else if (addr == OFS_CLIP1)
			rdata_next = clip_reg[1];
		else if (addr == OFS_STAT)
			rdata_next = {23'h000000, busy_reg, 1'b0, new_st_reg, ow_st_reg, lim_st_reg, ctrl_reg[CTL_RUN]};
		else if (addr == OFS_RES0)
			rdata_next = 32'(res_reg[0]);
		else if (addr == OFS_RES1)
			rdata_next = 32'(res_reg[1]);
		else if (addr == OFS_PEAK0)
			rdata_next = 32'(peak_reg[0]);
		else if (addr == OFS_PEAK1)
			rdata_next = 32'(peak_reg[1]);
		else if (addr == OFS_LIDX)
			rdata_next = {5'h00, log_cnt_reg[1], 5'h00, log_cnt_reg[0]};
		else if (addr == OFS_LOG0)
			rdata_next = (lidx_reg < 11'(LOG_DEPTH)) ? 32'(log_mem[0][lidx_reg]) : 32'h00000000;
		else if (addr == OFS_LOG1)
			rdata_next = (lidx_reg < 11'(LOG_DEPTH)) ? 32'(log_mem[1][lidx_reg]) : 32'h00000000;
		else
			rerr_next = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h00000000 : rdata_next;
			pslverr <= rerr_next;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= '0;
			cfg_reg <= '{default: CFG_RST};
			cal_reg <= '{default: {16'h0000, GAIN_RST}};
			clip_reg <= '{default: {CLIP_MAX_RST, CLIP_MIN_RST}};
			lidx_reg <= '0;
		end
		else if (wr_en)
		begin
			if (addr == OFS_CTRL)
				ctrl_reg <= {1'b0, pwdata[7:0]};
			else if (addr == OFS_CFG0)
				cfg_reg[0] <= pwdata[20:0];
			else if (addr == OFS_CFG1)
				cfg_reg[1] <= pwdata[20:0];
			else if (addr == OFS_CAL0)
				cal_reg[0] <= pwdata;
			else if (addr == OFS_CAL1)
				cal_reg[1] <= pwdata;
			else if (addr == OFS_CLIP0)
				clip_reg[0] <= pwdata;
			else if (addr == OFS_CLIP1)
				clip_reg[1] <= pwdata;
			else if (addr == OFS_LIDX)
				lidx_reg <= pwdata[10:0];
		end
	end

	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			cal[c] = {clip_reg[c][31:16], clip_reg[c][15:0], cal_reg[c][31:16], cal_reg[c][15:0],
				dadc_range_t'(cfg_reg[c][CFG_RNG +: 3])};
			proc[c] = {dadc_flt_t'(cfg_reg[c][CFG_FLT +: 2]), cfg_reg[c][CFG_SH +: 4],
				dadc_avg_t'(cfg_reg[c][CFG_AVG +: 2]), cfg_reg[c][CFG_CNT +: 10]};
		end
	end

	// Trigger pins pass two flops; the third only feeds the edge compare.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trig_s1_reg <= '0;
			trig_s2_reg <= '0;
			trig_s3_reg <= '0;
			led_in <= '0;
		end
		else
		begin
			trig_s1_reg <= trig_pin;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
			led_in <= trig_s2_reg;
		end
	end

	always_comb
	begin
		for (int c = 0; c < 2; c++)
			edge_hit[c] = ctrl_reg[CTL_FALL + c] ? (trig_s3_reg[c] & ~trig_s2_reg[c])
				: (trig_s2_reg[c] & ~trig_s3_reg[c]);
	end

	always_comb
	begin
		case (ctrl_reg[CTL_CYC +: 2])
			2'b00: period = 16'(P_CYC_20);
			2'b01: period = 16'(P_CYC_40);
			default: period = 16'(P_CYC_80);
		endcase
		tick = ctrl_reg[CTL_RUN] && tmr_reg == period - 16'h0001;
		for (int c = 0; c < 2; c++)
			acc_next[c] = ctrl_reg[CTL_TEN + c] ? edge_hit[c] : tick;
		start_next = ctrl_reg[CTL_RUN] & ~busy_reg & (|acc_next);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tmr_reg <= '0;
		else if (!ctrl_reg[CTL_RUN] || tick)
			tmr_reg <= '0;
		else
			tmr_reg <= tmr_reg + 16'h0001;
	end

	// One start converts both channels together; a trigger during a conversion is dropped.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			adc_start <= 1'b0;
			busy_reg <= 1'b0;
			acc_reg <= '0;
		end
		else
		begin
			adc_start <= start_next;
			if (start_next)
			begin
				busy_reg <= 1'b1;
				acc_reg <= acc_next;
			end
			else if (adc_valid)
				busy_reg <= 1'b0;
		end
	end

	assign ch_in = {2{busy_reg & adc_valid}} & acc_reg;

	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		dadc_chan u_chan (
			.pclk(pclk),
			.presetn(presetn),
			.in_valid(ch_in[c]),
			.smp(adc_smp[c]),
			.cal(cal[c]),
			.out_valid(ch_ov[c]),
			.res(ch_res[c]),
			.lim_err(ch_lim[c]),
			.open_wire(ch_ow[c])
		);
		dadc_filt u_filt (
			.pclk(pclk),
			.presetn(presetn),
			.clr(clr_pulse),
			.in_valid(ch_ov[c]),
			.x(ch_res[c]),
			.cfg(proc[c]),
			.out_valid(fl_ov[c]),
			.y(fl_y[c])
		);
	end

	// Status bits are write-one-to-clear; a new event in the same cycle wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lim_st_reg <= '0;
			ow_st_reg <= '0;
			new_st_reg <= '0;
		end
		else
		begin
			if (wr_en && addr == OFS_STAT)
			begin
				lim_st_reg <= (lim_st_reg & ~pwdata[2:1]) | (ch_ov & ch_lim);
				ow_st_reg <= (ow_st_reg & ~pwdata[4:3]) | (ch_ov & ch_ow);
				new_st_reg <= (new_st_reg & ~pwdata[6:5]) | fl_ov;
			end
			else
			begin
				lim_st_reg <= lim_st_reg | (ch_ov & ch_lim);
				ow_st_reg <= ow_st_reg | (ch_ov & ch_ow);
				new_st_reg <= new_st_reg | fl_ov;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			res_reg <= '{default: '0};
			peak_reg <= '{default: 16'h8000};
			log_cnt_reg <= '{default: '0};
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (fl_ov[c])
					res_reg[c] <= fl_y[c];
				if (clr_pulse)
				begin
					peak_reg[c] <= 16'h8000;
					log_cnt_reg[c] <= '0;
				end
				else if (fl_ov[c])
				begin
					if (fl_y[c] > peak_reg[c])
						peak_reg[c] <= fl_y[c];
					if (ctrl_reg[CTL_LOG] && log_cnt_reg[c] < 11'(LOG_DEPTH))
						log_cnt_reg[c] <= log_cnt_reg[c] + 11'h001;
				end
			end
		end
	end

	always_ff @(posedge pclk)
	begin
		for (int c = 0; c < 2; c++)
			if (!clr_pulse && fl_ov[c] && ctrl_reg[CTL_LOG] && log_cnt_reg[c] < 11'(LOG_DEPTH))
				log_mem[c][log_cnt_reg[c]] <= fl_y[c];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blink_cnt_reg <= '0;
			blink_reg <= 1'b0;
		end
		else if (blink_cnt_reg >= 32'(P_BLINK - 1))
		begin
			blink_cnt_reg <= '0;
			blink_reg <= ~blink_reg;
		end
		else
			blink_cnt_reg <= blink_cnt_reg + 32'h00000001;
	end

	// Disconnection counts as serious, a limit error as minor.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			led_err <= 1'b0;
			led_conv <= 1'b0;
		end
		else
		begin
			led_err <= (|ow_st_reg) ? 1'b1 : ((|lim_st_reg) ? blink_reg : 1'b0);
			led_conv <= ctrl_reg[CTL_RUN] & blink_reg;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	both_chan_a: assert property (busy_reg && adc_valid && acc_reg == 2'b11 |=> ##1 ch_ov == 2'b11)
		else $error("Channels of one start not processed together");
	tick_gap_a: assert property (tick && ctrl_reg[CTL_RUN] |=> !tick [*1] ##0 tmr_reg == 16'h0000)
		else $error("Sample timer not restarted after a tick");
	trig_start_a: assert property (ctrl_reg[CTL_RUN] && ctrl_reg[CTL_TEN] && edge_hit[0] && !busy_reg
		|=> adc_start && acc_reg[0])
		else $error("Enabled trigger edge did not start a conversion");
	log_bound_a: assert property (log_cnt_reg[0] <= 11'(LOG_DEPTH) && log_cnt_reg[1] <= 11'(LOG_DEPTH))
		else $error("Log count beyond its depth");
	peak_hold_a: assert property (fl_ov[0] && !clr_pulse |=> peak_reg[0] >= $past(fl_y[0]))
		else $error("Peak below a newer result");
	err_led_a: assert property (|ow_st_reg |=> led_err)
		else $error("Error indicator not steady on serious error");
	conv_led_a: assert property (!ctrl_reg[CTL_RUN] |=> !led_conv)
		else $error("Conversion indicator lit while stopped");
	in_led_a: assert property (trig_s2_reg[1] |=> led_in[1])
		else $error("Input indicator does not follow the input point");
	start_cov: cover property (adc_start ##[1:300] adc_valid);
	trig_cov: cover property (edge_hit[0] && ctrl_reg[CTL_TEN] && start_next);
	lim_cov: cover property (|lim_st_reg);
	log_full_cov: cover property (log_cnt_reg[0] == 11'(LOG_DEPTH));
endmodule : dadc_top

// ==== dadc_fe_model.sv ====
/*
 Front-end model: converts both channels on one adc_start, answers 6 cycles later.
 Assumes dadc_pkg and the block's pclk and presetn.
*/
`timescale 1ns/1ps
module dadc_fe_model
	import dadc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic adc_start,
	input wire dadc_sample_t [1:0] smp_set,
	output dadc_sample_t [1:0] adc_smp,
	output logic adc_valid
);
	int cnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 0;
			adc_valid <= 1'b0;
			adc_smp <= '0;
		end
		else
		begin
			// Outside the valid cycle the results are scrambled so stale data is not mistaken for fresh.
			adc_valid <= (cnt == 1);
			adc_smp <= (cnt == 1) ? smp_set : ~adc_smp;
			cnt <= adc_start ? 5 : (cnt > 0 ? cnt - 1 : 0);
		end
	end
endmodule : dadc_fe_model

// ==== dual_adc_result_processing_tb.sv ====
/*
 Testbench: APB master, front-end model, result checks through an expectation queue.
 Assumes dadc_top with short sample periods and blink count.
*/
`timescale 1ns/1ps
module dual_adc_result_processing_tb;
	import dadc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, adc_valid, adc_start, led_err, led_conv, conv_hi;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] trig_pin, led_in;
	logic [33:0] ent;
	logic [33:0] expq[$];
	dadc_sample_t [1:0] adc_smp, smp_set;
	int err_total, checks, seed, cyc_n, last_st, per_exp, code, e0, e1;

	dadc_top #(.P_CYC_20(20), .P_CYC_40(40), .P_CYC_80(80), .P_BLINK(4)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adc_smp(adc_smp), .adc_valid(adc_valid), .adc_start(adc_start),
		.trig_pin(trig_pin), .led_err(led_err), .led_conv(led_conv), .led_in(led_in));
	dadc_fe_model fe_u (.pclk(pclk), .presetn(presetn), .adc_start(adc_start), .smp_set(smp_set),
		.adc_smp(adc_smp), .adc_valid(adc_valid));

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			err_total++;
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	// Expectation word: bit 33 compare data, bit 32 expected pslverr, low word expected data.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
		int n;
		expq.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			err_total++;
			end_sim();
		end
	endtask : xfer

	always @(posedge pclk)
	begin
		cyc_n <= cyc_n + 1;
		if (led_conv === 1'b1)
			conv_hi <= 1'b1;
		if (pready === 1'b1 && expq.size() > 0)
		begin
			ent = expq.pop_front();
			chk("pslverr", {31'h0, pslverr}, {31'h0, ent[32]});
			if (ent[33])
				chk("prdata", prdata, ent[31:0]);
		end
		if (adc_start === 1'b1)
		begin
			if (last_st > 0)
				chk("start period", cyc_n - last_st, per_exp);
			last_st <= cyc_n;
		end
	end

	initial
	begin
		seed = 68329;
		{presetn, psel, penable, pwrite, paddr, pwdata, trig_pin, smp_set} = '0;
		{err_total, checks, cyc_n, last_st, per_exp} = '0;
		conv_hi = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, OFS_CFG0, 32'h0, {2'b10, 32'h20});
		xfer(1'b0, OFS_CAL0, 32'h0, {2'b10, 32'h1000});
		xfer(1'b0, OFS_CLIP0, 32'h0, {2'b10, 32'h7E808180});
		xfer(1'b0, 8'hFC, 32'h0, {2'b11, 32'h0});
		xfer(1'b1, OFS_CFG1, 32'h27, 34'h0);
		trig_pin <= 2'b10;
		repeat (6) @(posedge pclk);
		chk("led_in", {30'h0, led_in}, 32'h2);
		for (int i = 0; i < 8; i++)
		begin
			code = $random(seed) & 16'h3FFF;
			if (i == 4 || i == 7)
				code = code + 6400;
			e0 = (i == 4 || i == 7) ? (code - 6400) * 5 / 4 : code;
			e1 = i[0] ? LIM_HI : LIM_UNI_LO;
			smp_set <= {16'h1234, i[0], ~i[0], code[15:0], 2'b00};
			per_exp <= (i % 3 == 0) ? 20 : (i % 3 == 1) ? 40 : 80;
			last_st <= 0;
			conv_hi <= 1'b0;
			xfer(1'b1, OFS_CFG0, 32'h20 | i, 34'h0);
			xfer(1'b1, OFS_STAT, 32'h7E, 34'h0);
			xfer(1'b1, OFS_CTRL, 1 | (i % 3) << 1, 34'h0);
			repeat (250) @(posedge pclk);
			chk("led_conv run", {31'h0, conv_hi}, 32'h1);
			xfer(1'b1, OFS_CTRL, 32'h0, 34'h0);
			repeat (30) @(posedge pclk);
			chk("led_conv stop", {31'h0, led_conv}, 32'h0);
			if (!i[0])
				chk("led_err", {31'h0, led_err}, 32'h1);
			xfer(1'b0, OFS_RES0, 32'h0, {2'b10, e0});
			xfer(1'b0, OFS_RES1, 32'h0, {2'b10, e1});
			xfer(1'b0, OFS_STAT, 32'h0, {2'b10, 32'h64 | (i[0] ? 32'h0 : 32'h10)});
		end
		// Falling-edge triggers on channel 0, 10 kHz, with a time average over two samples.
		last_st <= 0;
		per_exp <= 12500;
		xfer(1'b1, OFS_CFG0, 32'h48, 34'h0);
		xfer(1'b1, OFS_CTRL, 32'h1B9, 34'h0);
		e0 = 0;
		for (int j = 0; j < 2; j++)
		begin
			code = $random(seed) & 16'h3FFF;
			e0 = e0 + code;
			smp_set <= {16'h1234, 2'b00, code[15:0], 2'b00};
			trig_pin[0] <= 1'b1;
			repeat (6250) @(posedge pclk);
			chk("led_in both", {30'h0, led_in}, 32'h3);
			trig_pin[0] <= 1'b0;
			repeat (6250) @(posedge pclk);
		end
		e0 = e0 / 2;
		xfer(1'b0, OFS_RES0, 32'h0, {2'b10, e0});
		xfer(1'b0, OFS_PEAK0, 32'h0, {2'b10, e0});
		xfer(1'b0, OFS_LIDX, 32'h0, {2'b10, 32'h1});
		xfer(1'b0, OFS_LOG0, 32'h0, {2'b10, e0});
		xfer(1'b1, OFS_STAT, 32'h7E, 34'h0);
		repeat (4) @(posedge pclk);
		chk("led_err clear", {31'h0, led_err}, 32'h0);
		end_sim();
	end
endmodule : dual_adc_result_processing_tb
